// ===== logic/esp_pkg.sv
// Purpose: Constants and types shared by the enhanced serial port
// Assumes: 50 MHz clock, byte addressed Avalon-MM register window
// Notes:   Status and mask registers share the IS_* bit layout
package esp_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] OFS_POWER_CONTROL  = 8'h9C;
  localparam logic [7:0] OFS_STATION_ADDR   = 8'hA0;
  localparam logic [7:0] OFS_STATION_MASK   = 8'hA4;
  localparam logic [7:0] OFS_TX_DATA        = 8'hA8;
  localparam logic [7:0] OFS_RX_DATA        = 8'hAC;
  localparam logic [7:0] OFS_BAUD_DIV       = 8'hB0;
  localparam logic [7:0] OFS_INT_STATUS     = 8'hB4;
  localparam logic [7:0] OFS_INT_MASK       = 8'hB8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SC_MODE_HI   = 7;
  localparam int SC_MODE_LO   = 6;
  localparam int SC_ADDR_FILT = 5;
  localparam int SC_RX_EN     = 4;
  localparam int SC_TX9       = 3;
  localparam int SC_RX9       = 2;
  localparam int SC_TX_DONE   = 1;
  localparam int SC_RX_DONE   = 0;
  localparam int PC_DOUBLE    = 7;
  localparam int PC_ERR_SEL   = 6;
  localparam int IS_RX        = 0;
  localparam int IS_TX        = 1;
  localparam int IS_FE        = 2;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_RESET = 8'h00;
  localparam logic [7:0]  MASK_RESET = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h001A;
  localparam logic [3:0]  OVS_LAST   = 4'hF;
  localparam logic [3:0]  OVS_MID    = 4'h7;
  localparam logic [3:0]  M0_LAST    = 4'hB;
  localparam logic [3:0]  M0_HALF    = 4'h6;
  localparam int          OVS_TICKS  = 16;
  localparam int          M2_BIT_SLOW = 64;
  localparam int          M2_BIT_FAST = 32;
  localparam logic [15:0] M2_DIV_SLOW = 16'(M2_BIT_SLOW / OVS_TICKS - 1);
  localparam logic [15:0] M2_DIV_FAST = 16'(M2_BIT_FAST / OVS_TICKS - 1);

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00, MODE_UART8 = 2'b01,
    MODE_UART9_FIX = 2'b10, MODE_UART9_VAR = 2'b11
  } esp_mode_e;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_STOP = 3'b011, TX_SHIFT = 3'b100
  } esp_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_STOP = 3'b011, RX_SHIFT = 3'b100
  } esp_rx_e;
endpackage

// ===== logic/esp_tick.sv
// Purpose: Sixteen-times oversample enable for the asynchronous modes
// Assumes: One clock; tick is a one-cycle enable, never a clock
// Notes:   Period is reload+1 cycles, or fixed for the 9-bit fixed mode
module esp_tick (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Rate selection
  input  wire logic        fixed_rate,
  input  wire logic        double_rate,
  input  wire logic [15:0] reload,
  // Oversample enable
  output logic             tick
);
  import esp_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } esp_tick_s;

  esp_tick_s   s;
  esp_tick_s   next_s;
  logic [15:0] period;

  // Free-running divider, restarts at zero on each tick
  always_comb begin
    period = fixed_rate ? (double_rate ? M2_DIV_FAST : M2_DIV_SLOW)
                        : reload;
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt >= period) begin
      next_s.cnt  = 16'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule // esp_tick

// ===== logic/esp_serial_port.sv
// Purpose: Enhanced serial port with four modes and address filtering
// Assumes: Avalon-MM slave with waitrequest, synchronous active-low reset
// Notes:   Shift mode clock is clk/12; async modes oversample by 16
// Contract
// - A bad or missing stop bit sets the framing error flag in bit 7.
// - Bit 7 is the framing flag when error select is one, else mode high.
// - The framing flag stays set across good frames until software clears it.
// - Mode bits high,low pick shift, 8-bit, 9-bit fixed or 9-bit variable.
// - In 9-bit modes with filtering, done needs ninth bit one and a match.
// - In 8-bit mode with filtering, done needs a good stop bit and a match.
// - Reception starts only while the receive enable bit is one.
// - In 9-bit modes the written ninth bit is sent as the ninth data bit.
// - In 9-bit modes the received ninth bit is stored in rx_ninth_bit.
// - In 8-bit mode without filtering the stop bit goes to rx_ninth_bit.
// - Transmit done sets after bit 8 in shift mode, else at stop start.
// - Receive done sets after bit 8 in shift mode, else mid stop bit.
// - The given address is station address masked, zeros don't care.
// - Broadcast is address OR mask, zero bits of it don't care.
// - Station address and mask both reset to zero, so all bytes match.
//
// Added by the designer: the Avalon-MM interface to the registers.
module esp_serial_port (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Register bus
  input  wire logic [esp_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [esp_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [esp_pkg::DATA_W-1:0] avs_readdata,
  output logic                            avs_waitrequest,
  // Serial pins
  input  wire logic                       rxd_in,
  output logic                            rxd_out,
  output logic                            rxd_oe,
  output logic                            txd,
  // Interrupt
  output logic                            irq
);
  import esp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wreq;
    logic [15:0] rdata;
    logic        irq;
    logic        sm0, sm1, sm2, ren, tb8, rb8, ti, ri, fe;
    logic        error_flag_select, smod1;
    logic [7:0]  station_address, station_address_mask, rxbuf;
    logic [15:0] bdiv;
    logic [2:0]  ist, imask;
    logic        rxs1, rxs2, rx_q;
    esp_tx_e     tx_st;
    logic [8:0]  tx_sh;
    logic [3:0]  tx_cnt, tx_tk;
    logic        txd, rxd_o, rxd_oe;
    esp_rx_e     rx_st;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_cnt, rx_tk;
  } esp_state_s;

  esp_state_s s;
  esp_state_s next_s;
  logic       tick, hit, wr, tx_wr, rx_fin, sb, ninth, addr_ok, filt;
  logic       accept, bit7_v, ev_rx, ev_tx, ev_fe;
  logic [7:0] wd, rx_byte;
  logic [3:0] nbits;
  esp_mode_e  mode;

  // Given or broadcast address match
  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [7:0] a,
                                      input logic [7:0] m);
    logic [7:0] bc;
    bc = a | m;
    return (((b ^ a) & m) == 8'h00)
        || ((b & bc) == bc);
  endfunction

  // ----------------------------------------------------------------
  // Oversample enable
  // ----------------------------------------------------------------
  esp_tick u_tick (
    .clk         (clk),
    .resetn      (resetn),
    .fixed_rate  (mode == MODE_UART9_FIX),
    .double_rate (s.smod1),
    .reload      (s.bdiv),
    .tick        (tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    ev_rx  = 1'b0;
    ev_tx  = 1'b0;
    ev_fe  = 1'b0;
    rx_fin = 1'b0;
    sb     = 1'b0;
    mode   = esp_mode_e'({s.sm0, s.sm1});
    nbits  = (mode == MODE_UART8) ? 4'h8 : 4'h9;
    wd     = avs_writedata[7:0];
    bit7_v = s.error_flag_select ? s.fe : s.sm0;

    // Answer one cycle after the request is seen
    hit = (avs_read | avs_write) & ~s.wreq;
    wr  = hit & avs_write & avs_byteenable[0];
    next_s.wreq = ~((avs_read | avs_write) & s.wreq);
    tx_wr = wr && (avs_address == OFS_TX_DATA);

    // Read value prepared while waitrequest is still high
    unique case (avs_address)
      OFS_SERIAL_CONTROL: next_s.rdata = {8'h00, bit7_v, s.sm1, s.sm2,
                            s.ren, s.tb8, s.rb8, s.ti, s.ri};
      OFS_POWER_CONTROL:  next_s.rdata = {8'h00, s.smod1, s.error_flag_select, 6'h00};
      OFS_STATION_ADDR:   next_s.rdata = {8'h00, s.station_address};
      OFS_STATION_MASK:   next_s.rdata = {8'h00, s.station_address_mask};
      OFS_RX_DATA:        next_s.rdata = {8'h00, s.rxbuf};
      OFS_BAUD_DIV:       next_s.rdata = s.bdiv;
      OFS_INT_STATUS:     next_s.rdata = {13'h0000, s.ist};
      OFS_INT_MASK:       next_s.rdata = {13'h0000, s.imask};
      default:            next_s.rdata = 16'h0000;
    endcase

    // Register writes; hardware sets below override them
    if (wr) begin
      unique case (avs_address)
        OFS_SERIAL_CONTROL: begin
          if (s.error_flag_select) begin
            next_s.fe = wd[SC_MODE_HI];
          end else begin
            next_s.sm0 = wd[SC_MODE_HI];
          end
          next_s.sm1 = wd[SC_MODE_LO];
          next_s.sm2 = wd[SC_ADDR_FILT];
          next_s.ren = wd[SC_RX_EN];
          next_s.tb8 = wd[SC_TX9];
          next_s.rb8 = wd[SC_RX9];
          next_s.ti  = wd[SC_TX_DONE];
          next_s.ri  = wd[SC_RX_DONE];
        end
        OFS_POWER_CONTROL: begin
          next_s.smod1 = wd[PC_DOUBLE];
          next_s.error_flag_select = wd[PC_ERR_SEL];
        end
        OFS_STATION_ADDR: next_s.station_address = wd;
        OFS_STATION_MASK: next_s.station_address_mask = wd;
        OFS_BAUD_DIV:     next_s.bdiv[7:0] = wd;
        OFS_INT_STATUS:   next_s.ist = s.ist & ~wd[2:0];
        OFS_INT_MASK:     next_s.imask = wd[2:0];
        default: ;
      endcase
    end
    if (hit && avs_write && avs_byteenable[1]
        && avs_address == OFS_BAUD_DIV) begin
      next_s.bdiv[15:8] = avs_writedata[15:8];
    end

    // Pin synchroniser and edge history
    next_s.rxs1 = rxd_in;
    next_s.rxs2 = s.rxs1;
    next_s.rx_q = s.rxs2;

    // Transmitter
    if (tick && s.tx_st != TX_IDLE && s.tx_st != TX_SHIFT) begin
      next_s.tx_tk = s.tx_tk + 4'h1;
    end
    unique case (s.tx_st)
      TX_IDLE: begin
        if (tx_wr && mode == MODE_SHIFT && s.rx_st == RX_IDLE) begin
          next_s.tx_st  = TX_SHIFT;
          next_s.tx_sh  = {1'b0, wd};
          next_s.tx_tk  = 4'h0;
          next_s.tx_cnt = 4'h0;
          next_s.rxd_oe = 1'b1;
          next_s.rxd_o  = wd[0];
          next_s.txd    = 1'b0;
        end else if (tx_wr && mode != MODE_SHIFT) begin
          next_s.tx_st  = TX_START;
          next_s.tx_sh  = {s.tb8, wd};
          next_s.tx_tk  = 4'h0;
          next_s.tx_cnt = 4'h0;
          next_s.txd    = 1'b0;
        end
      end
      TX_START: if (tick && s.tx_tk == OVS_LAST) begin
        next_s.tx_st  = TX_DATA;
        next_s.txd    = s.tx_sh[0];
        next_s.tx_sh  = {1'b0, s.tx_sh[8:1]};
        next_s.tx_cnt = 4'h1;
      end
      TX_DATA: if (tick && s.tx_tk == OVS_LAST) begin
        if (s.tx_cnt == nbits) begin
          next_s.tx_st = TX_STOP;
          next_s.txd   = 1'b1;
          next_s.ti    = 1'b1;
          ev_tx        = 1'b1;
        end else begin
          next_s.txd    = s.tx_sh[0];
          next_s.tx_sh  = {1'b0, s.tx_sh[8:1]};
          next_s.tx_cnt = s.tx_cnt + 4'h1;
        end
      end
      TX_STOP: if (tick && s.tx_tk == OVS_LAST) begin
        next_s.tx_st = TX_IDLE;
      end
      TX_SHIFT: begin
        // Clock low for six phases, high for six; data moves on low
        if (s.tx_tk == M0_LAST) begin
          next_s.tx_tk = 4'h0;
          next_s.txd   = 1'b0;
          if (s.tx_cnt == 4'h7) begin
            next_s.tx_st  = TX_IDLE;
            next_s.txd    = 1'b1;
            next_s.rxd_oe = 1'b0;
            next_s.ti     = 1'b1;
            ev_tx         = 1'b1;
          end else begin
            next_s.tx_cnt = s.tx_cnt + 4'h1;
            next_s.tx_sh  = {1'b0, s.tx_sh[8:1]};
            next_s.rxd_o  = s.tx_sh[1];
          end
        end else begin
          next_s.tx_tk = s.tx_tk + 4'h1;
          next_s.txd   = (s.tx_tk + 4'h1) >= M0_HALF;
        end
      end
      default: next_s.tx_st = TX_IDLE;
    endcase

    // Receiver
    if (tick && s.rx_st != RX_IDLE && s.rx_st != RX_SHIFT) begin
      next_s.rx_tk = s.rx_tk + 4'h1;
    end
    unique case (s.rx_st)
      RX_IDLE: if (s.ren) begin
        if (mode != MODE_SHIFT && s.rx_q && !s.rxs2) begin
          next_s.rx_st  = RX_START;
          next_s.rx_tk  = 4'h0;
          next_s.rx_cnt = 4'h0;
        end else if (mode == MODE_SHIFT && !s.ri
                     && s.tx_st == TX_IDLE && !tx_wr) begin
          next_s.rx_st  = RX_SHIFT;
          next_s.rx_tk  = 4'h0;
          next_s.rx_cnt = 4'h0;
          next_s.txd    = 1'b0;
        end
      end
      RX_START: if (tick && s.rx_tk == OVS_MID && s.rxs2) begin
        next_s.rx_st = RX_IDLE;          // Glitch, not a start bit
      end else if (tick && s.rx_tk == OVS_LAST) begin
        next_s.rx_st = RX_DATA;
      end
      RX_DATA: if (tick && s.rx_tk == OVS_MID) begin
        next_s.rx_sh  = {s.rxs2, s.rx_sh[8:1]};
        next_s.rx_cnt = s.rx_cnt + 4'h1;
      end else if (tick && s.rx_tk == OVS_LAST && s.rx_cnt == nbits) begin
        next_s.rx_st = RX_STOP;
      end
      RX_STOP: if (tick && s.rx_tk == OVS_MID) begin
        rx_fin       = 1'b1;
        sb           = s.rxs2;
        next_s.rx_st = RX_IDLE;
      end
      RX_SHIFT: begin
        if (s.rx_tk == M0_LAST) begin
          next_s.rx_tk = 4'h0;
          next_s.txd   = 1'b0;
          if (s.rx_cnt == 4'h7) begin
            next_s.rx_st = RX_IDLE;
            next_s.txd   = 1'b1;
            next_s.rxbuf = s.rx_sh[8:1];
            next_s.ri    = 1'b1;
            ev_rx        = 1'b1;
          end else begin
            next_s.rx_cnt = s.rx_cnt + 4'h1;
          end
        end else begin
          next_s.rx_tk = s.rx_tk + 4'h1;
          next_s.txd   = (s.rx_tk + 4'h1) >= M0_HALF;
          // Sample on the rising shift clock
          if (s.rx_tk + 4'h1 == M0_HALF) begin
            next_s.rx_sh = {s.rxs2, s.rx_sh[8:1]};
          end
        end
      end
      default: next_s.rx_st = RX_IDLE;
    endcase

    // End of an asynchronous frame
    rx_byte = (mode == MODE_UART8) ? s.rx_sh[8:1] : s.rx_sh[7:0];
    ninth   = s.rx_sh[8];
    addr_ok = addr_match(rx_byte, s.station_address, s.station_address_mask);
    if (mode == MODE_UART8) begin
      filt = !s.sm2 || (sb && addr_ok);
    end else begin
      filt = !s.sm2 || (ninth && addr_ok);
    end
    accept = rx_fin && !s.ri && filt;
    if (rx_fin && !sb) begin
      next_s.fe = 1'b1;
      ev_fe     = 1'b1;
    end
    if (accept) begin
      next_s.ri    = 1'b1;
      next_s.rxbuf = rx_byte;
      ev_rx        = 1'b1;
      if (mode != MODE_UART8) begin
        next_s.rb8 = ninth;
      end else if (!s.sm2) begin
        next_s.rb8 = sb;
      end
    end

    // Sticky events; a set in the clearing cycle wins
    next_s.ist = next_s.ist | {ev_fe, ev_tx, ev_rx};
    next_s.irq = |(next_s.ist & next_s.imask);
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s        <= '0;
      s.wreq   <= 1'b1;
      s.station_address  <= ADDR_RESET;
      s.station_address_mask  <= MASK_RESET;
      s.bdiv   <= BAUD_RESET;
      s.txd    <= 1'b1;
      s.rxs1   <= 1'b1;
      s.rxs2   <= 1'b1;
      s.rx_q   <= 1'b1;
      s.tx_st  <= TX_IDLE;
      s.rx_st  <= RX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign avs_readdata    = {16'h0000, s.rdata};
  assign avs_waitrequest = s.wreq;
  assign rxd_out         = s.rxd_o;
  assign rxd_oe          = s.rxd_oe;
  assign txd             = s.txd;
  assign irq             = s.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic wr_serial_control;
  assign wr_serial_control = wr && (avs_address == OFS_SERIAL_CONTROL);

  sequence bad_stop_s;
    rx_fin && !sb;
  endsequence
  sequence clean_hold_s;
    !(wr_serial_control && s.error_flag_select) [*3];
  endsequence

  fe_set_a: assert property (@(posedge clk) disable iff (!resetn)
    bad_stop_s |=> s.fe)
    else $error("framing error not flagged");
  fe_sticky_a: assert property (@(posedge clk) disable iff (!resetn)
    s.fe ##0 clean_hold_s |=> s.fe)
    else $error("framing error cleared without write");
  bit7_read_a: assert property (@(posedge clk) disable iff (!resetn)
    hit && avs_read && avs_address == OFS_SERIAL_CONTROL
    |-> s.rdata[7] == $past(bit7_v))
    else $error("bit 7 readback wrong");
  shift_mode_a: assert property (@(posedge clk) disable iff (!resetn)
    s.rx_st == RX_IDLE && next_s.rx_st == RX_SHIFT
    |-> mode == MODE_SHIFT)
    else $error("shift receive outside mode 0");
  filt9_a: assert property (@(posedge clk) disable iff (!resetn)
    rx_fin && s.sm0 && s.sm2 && !ninth && !s.ri && !wr_serial_control
    |=> !s.ri)
    else $error("data byte passed address filter");
  filt8_a: assert property (@(posedge clk) disable iff (!resetn)
    rx_fin && mode == MODE_UART8 && s.sm2 && !sb && !s.ri
    && !wr_serial_control |=> !s.ri)
    else $error("bad stop passed filter");
  ren_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    !s.ren && s.rx_st == RX_IDLE |=> s.rx_st == RX_IDLE)
    else $error("reception while disabled");
  rb8_stop_a: assert property (@(posedge clk) disable iff (!resetn)
    accept && mode == MODE_UART8 && !s.sm2 && !wr_serial_control
    |=> s.rb8 == $past(sb))
    else $error("stop bit not in rx_ninth_bit");
  ti_stop_a: assert property (@(posedge clk) disable iff (!resetn)
    s.tx_st == TX_DATA && next_s.tx_st == TX_STOP
    |=> s.ti && s.txd ##1 s.txd)
    else $error("transmit done not at stop start");
  addr_reset_a: assert property (@(posedge clk)
    $rose(resetn) |-> s.station_address == 8'h00 && s.station_address_mask == 8'h00)
    else $error("station address not cleared");
endmodule // esp_serial_port

// ===== test/esp_remote.sv
// Purpose: Remote serial station on the line side of the port
// Assumes: Async frames of BIT clocks per bit
// Notes:   Line rests high between frames, as a UART line idles
module esp_remote #(parameter int BIT = 16) (
  // Line
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1;
  // Frame out: low start, LSB first, optional ninth, stop
  task automatic send(input logic [7:0] d, input logic n9,
                      input logic has9, input logic stop);
    logic [10:0] f;
    f = {stop, n9, d, 1'b0};
    if (!has9) f[9] = stop;
    for (int i = 0; i < (has9 ? 11 : 10); i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask
  // Frame in: mid-bit sampling, bounded wait for the start edge
  task automatic recv(output logic [8:0] d);
    int k;
    d = 9'h1FF;
    for (k = 0; k < 2000 && txd !== 1'b0; k++) @(posedge clk);
    if (txd === 1'b0) begin
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge clk);
        d[i] = txd;
      end
    end
  endtask
endmodule // esp_remote

// ===== test/esp_serial_port_tb.sv
// Purpose: Self-checking bench for the enhanced serial port
// Assumes: baud_div 0, so 16 clocks per async bit
// Notes:   Mode 2 timing and mode 0 receive are left to later work
module esp_serial_port_tb;
  import esp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, resetn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        avs_waitrequest, rxd_in, rxd_out, rxd_oe, txd, irq;
  int          n_fail = 0, n_compared = 0;
  esp_serial_port dut (.clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .rxd_in, .rxd_out, .rxd_oe, .txd, .irq);
  esp_remote #(.BIT(16)) rem (.clk(clk), .txd(txd), .rxd(rxd_in));
  initial forever #10 clk = ~clk;
  // ---------------------------------------------------------------
  // Bus and check helpers
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [7:0] d, output logic [31:0] q);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic ck(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    n_compared++;
    if ((q & {24'hFF_FFFF, m}) !== {24'h0, e}) begin
      n_fail++;
      $display("mismatch reg %h expected %h seen %h", a, e, q);
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    ck(OFS_STATION_ADDR, 8'hFF, 8'h00);
    ck(OFS_STATION_MASK, 8'hFF, 8'h00);
    ck(8'hFC, 8'hFF, 8'h00);
    wr(OFS_BAUD_DIV, 8'h00);
  endtask
  // Enable off must drop a whole frame
  task automatic t_rx_off();
    wr(OFS_SERIAL_CONTROL, 8'h40);
    rem.send(8'h5A, 1'b0, 1'b0, 1'b1);
    ck(OFS_SERIAL_CONTROL, 8'h01, 8'h00);
  endtask
  task automatic t_rx8();
    wr(OFS_SERIAL_CONTROL, 8'h50);
    rem.send(8'hA5, 1'b0, 1'b0, 1'b1);
    ck(OFS_SERIAL_CONTROL, 8'hFF, 8'h55);
    ck(OFS_RX_DATA, 8'hFF, 8'hA5);
  endtask
  // Bad stop sets the flag; a good frame later must not clear it
  task automatic t_frame_err();
    wr(OFS_POWER_CONTROL, 8'h40);
    wr(OFS_SERIAL_CONTROL, 8'h50);
    rem.send(8'h12, 1'b0, 1'b0, 1'b0);
    ck(OFS_SERIAL_CONTROL, 8'h80, 8'h80);
    wr(OFS_SERIAL_CONTROL, 8'hD0);
    rem.send(8'h34, 1'b0, 1'b0, 1'b1);
    ck(OFS_SERIAL_CONTROL, 8'h81, 8'h81);
    wr(OFS_SERIAL_CONTROL, 8'h50);
    ck(OFS_SERIAL_CONTROL, 8'h80, 8'h00);
    wr(OFS_POWER_CONTROL, 8'h00);
  endtask
  // Given C0 with bit 1 free; broadcast FD with bit 1 free
  task automatic t_filter();
    logic [7:0] b[4] = '{8'h55, 8'hC0, 8'hC2, 8'hFF};
    logic [3:0] n9 = 4'b1101, hit = 4'b1100;
    wr(OFS_STATION_ADDR, 8'hC0);
    wr(OFS_STATION_MASK, 8'hFD);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SERIAL_CONTROL, 8'hF0);
      rem.send(b[i], n9[i], 1'b1, 1'b1);
      ck(OFS_SERIAL_CONTROL, 8'hC1, {7'h60, hit[i]});
    end
    ck(OFS_SERIAL_CONTROL, 8'h04, 8'h04);
  endtask
  // Nine-bit send, done flag, interrupt masked then raised
  task automatic t_tx();
    logic [8:0] d;
    wr(OFS_INT_MASK, 8'h00);
    wr(OFS_SERIAL_CONTROL, 8'hC8);
    fork
      rem.recv(d);
      wr(OFS_TX_DATA, 8'h3C);
    join
    n_compared++;
    if (d !== 9'h13C) begin
      n_fail++;
      $display("mismatch tx frame expected 13c seen %h", d);
    end
    repeat (16) @(posedge clk);
    ck(OFS_SERIAL_CONTROL, 8'h02, 8'h02);
    ck(OFS_INT_STATUS, 8'h02, 8'h02);
    wr(OFS_INT_MASK, 8'h02);
    repeat (3) @(posedge clk);
    n_compared++;
    if (irq !== 1'b1) begin
      n_fail++;
      $display("mismatch irq expected 1 seen %b", irq);
    end
    wr(OFS_INT_STATUS, 8'h02);
    repeat (3) @(posedge clk);
    n_compared++;
    if (irq !== 1'b0) begin
      n_fail++;
      $display("mismatch irq expected 0 seen %b", irq);
    end
  endtask
  // Shift mode send: eight bits on the data pin, LSB first, on rising clock
  task automatic t_shift_tx();
    logic [7:0] got;
    int         k;
    got = 8'h00;
    wr(OFS_SERIAL_CONTROL, 8'h00);
    wr(OFS_TX_DATA, 8'hA5);
    for (int i = 0; i < 8; i++) begin
      for (k = 0; k < 30 && txd !== 1'b0; k++) @(posedge clk);
      for (k = 0; k < 30 && txd !== 1'b1; k++) @(posedge clk);
      n_compared++;
      if (txd !== 1'b1 || rxd_oe !== 1'b1) begin
        n_fail++;
        $display("mismatch shift clk,oe expected 11 seen %b%b", txd, rxd_oe);
      end
      got[i] = rxd_out;
    end
    n_compared++;
    if (got !== 8'hA5) begin
      n_fail++;
      $display("mismatch shift data expected a5 seen %h", got);
    end
    repeat (20) @(posedge clk);
    n_compared++;
    if (rxd_oe !== 1'b0 || txd !== 1'b1) begin
      n_fail++;
      $display("mismatch shift idle oe,clk expected 01 seen %b%b", rxd_oe, txd);
    end
    ck(OFS_SERIAL_CONTROL, 8'h02, 8'h02);
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_rx_off();
    t_rx8();
    t_frame_err();
    t_filter();
    t_tx();
    t_shift_tx();
    end_of_test();
  end
endmodule // esp_serial_port_tb
